// file: design/dpr_pkg.sv
package dpr_pkg;
   // port geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 36;
   localparam int BE_W   = 4;
   localparam int NPORT  = 2;

   // apb map, byte addresses
   localparam int          PADDR_W      = 12;
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
   localparam logic [11:0] OFS_CNT_L    = 12'h010;
   localparam logic [11:0] OFS_CNT_R    = 12'h014;

   // field positions
   localparam int CTRL_SOFT_RST  = 0;
   localparam int IRQ_W          = 4;
   localparam int IRQ_MBOX_BASE  = 0;
   localparam int IRQ_WRAP_BASE  = 2;
   localparam int STAT_MBOX_BASE = 0;
   localparam int STAT_WRAP_BASE = 2;

   // values after reset
   localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
   localparam logic        FLAG_IDLE_N  = 1'b1;
endpackage : dpr_pkg

// file: design/port_if.sv
`timescale 1ns/1ns
`default_nettype none
// counter controls in, counter state out, one per port
interface port_if #(parameter int AW = 18);
   logic          ads_n;
   logic          counter_advance_enable_n_n;
   logic          cntrst_n;
   logic          cnt_sel;
   logic [AW-1:0] addr;
   logic [AW-1:0] cnt;
   logic          wrap_n;
   logic          wrap_evt;

   modport dev (input ads_n, counter_advance_enable_n_n, cntrst_n, cnt_sel, addr, output cnt, wrap_n, wrap_evt);
   modport ctl (output ads_n, counter_advance_enable_n_n, cntrst_n, cnt_sel, addr, input cnt, wrap_n, wrap_evt);
endinterface : port_if
`default_nettype wire

// file: design/port_counter.sv
`timescale 1ns/1ns
`default_nettype none
module port_counter
   import dpr_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic dev_rst_n,
   input  wire logic soft_clr,
   // counter controls and state
   port_if.dev       pi
);
   typedef struct packed {
      logic [AW-1:0] cnt;
      logic [AW-1:0] mask;
      logic          wrap_n;
      logic          wrap_evt;
   } cnt_state_s;

   cnt_state_s st_ff;
   cnt_state_s nxt_st;
   logic [AW-1:0] inc;

   // counter, mask and wrap flag next state
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.wrap_evt = 1'b0;
      inc             = ((st_ff.cnt | ~st_ff.mask) + AW'(1)) & st_ff.mask | (st_ff.cnt & ~st_ff.mask);
      if (soft_clr) begin
         nxt_st.cnt    = '0;
         nxt_st.mask   = '1;
         nxt_st.wrap_n = FLAG_IDLE_N;
      end else if (pi.cnt_sel) begin
         if (!pi.cntrst_n) begin
            // clear only the unmasked bits
            nxt_st.cnt    = st_ff.cnt & ~st_ff.mask;
            nxt_st.wrap_n = FLAG_IDLE_N;
         end else if (!pi.ads_n && !pi.counter_advance_enable_n_n) begin
            nxt_st.cnt    = pi.addr;
            nxt_st.wrap_n = FLAG_IDLE_N;
         end else if (pi.ads_n && !pi.counter_advance_enable_n_n) begin
            nxt_st.cnt      = inc;
            nxt_st.wrap_n   = ((inc & st_ff.mask) != st_ff.mask);
            nxt_st.wrap_evt = ((inc & st_ff.mask) == st_ff.mask);
         end
      end else begin
         // mask operations
         if (!pi.cntrst_n) begin
            nxt_st.mask = '0;
         end else if (!pi.ads_n && !pi.counter_advance_enable_n_n) begin
            nxt_st.mask = pi.addr;
         end
      end
   end

   // state register, cleared by master reset at any time
   always_ff @(posedge pclk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         st_ff <= '{cnt: '0, mask: '1, wrap_n: 1'b1, wrap_evt: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // state out to the top
   assign pi.cnt      = st_ff.cnt;
   assign pi.wrap_n   = st_ff.wrap_n;
   assign pi.wrap_evt = st_ff.wrap_evt;
endmodule : port_counter
`default_nettype wire

// file: design/dual_port_master_reset_flags.sv
// Overview of operation
// - master reset low resets all internal state
// - reset is asynchronous and hits both ports
// - reset zeroes counters, sets masks all ones
// - reset drives mailbox and wrap flags high
// - wrap flag low after an increment makes unmasked bits all ones
// - flow-through select picks flow-through or pipelined
// - enable without load strobe advances counter
// - mailbox flag set by peer write, owner read clears
`timescale 1ns/1ns
`default_nettype none
module dual_port_master_reset_flags
   import dpr_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // clock and resets
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            master_reset_n,
   // apb slave
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [PADDR_W-1:0]              paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   output logic                                 irq,
   // memory ports, index 0 left, 1 right
   input  wire logic [NPORT-1:0]                address_load_strobe_n,
   input  wire logic [NPORT-1:0]                counter_advance_enable_n,
   input  wire logic [NPORT-1:0]                counter_reset_n,
   input  wire logic [NPORT-1:0]                counter_mask_select,
   input  wire logic [NPORT-1:0][AW-1:0]        port_addr,
   input  wire logic [NPORT-1:0]                chip_enable_n,
   input  wire logic [NPORT-1:0]                read_write_n,
   input  wire logic [NPORT-1:0][BE_W-1:0]      byte_enable_n,
   input  wire logic [NPORT-1:0][DW-1:0]        write_data,
   input  wire logic [NPORT-1:0]                flow_through_select,
   // port outputs
   output logic      [NPORT-1:0][DW-1:0]        read_data,
   output logic      [NPORT-1:0]                mailbox_flag_n,
   output logic      [NPORT-1:0]                counter_wrap_flag_n
);
   typedef struct packed {
      logic [NPORT-1:0][DW-1:0] mbox;
      logic [NPORT-1:0]         mflag_n;
      logic [NPORT-1:0][DW-1:0] rd_stage;
      logic [NPORT-1:0][DW-1:0] rd_out;
      logic [IRQ_W-1:0]         irq_stat;
      logic [IRQ_W-1:0]         irq_mask;
      logic                     soft_clr;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     irq;
   } top_state_s;

   top_state_s             st_ff;
   top_state_s             nxt_st;
   logic                   dev_rst_n;
   // counter state and wrap events from the port counters
   logic [NPORT-1:0][AW-1:0] cnt_w;
   logic [NPORT-1:0]       wrap_n_w;
   logic [NPORT-1:0]       wrap_evt_w;

   // mailbox of owner sits at the top two addresses
   function automatic logic is_mbox(input logic [AW-1:0] a, input int owner);
      return a == {{(AW-1){1'b1}}, owner[0]};
   endfunction

   // mapped apb offset
   function automatic logic reg_hit(input logic [PADDR_W-1:0] a);
      return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_STAT) ||
             (a == OFS_IRQ_MASK) || (a == OFS_CNT_L) || (a == OFS_CNT_R);
   endfunction

   // either reset source clears everything, no clock needed
   // one clear net, so both ports leave reset together
   assign dev_rst_n = presetn & master_reset_n;

   // one counter per port
   // clock, combined reset and soft clear are shared between the two counters
   for (genvar g = 0; g < NPORT; g++) begin : g_port
      port_if #(.AW(AW)) pif ();
      assign pif.ads_n    = address_load_strobe_n[g];
      assign pif.counter_advance_enable_n_n  = counter_advance_enable_n[g];
      assign pif.cntrst_n = counter_reset_n[g];
      assign pif.cnt_sel  = counter_mask_select[g];
      assign pif.addr     = port_addr[g];
      assign cnt_w[g]      = pif.cnt;
      assign wrap_n_w[g]   = pif.wrap_n;
      assign wrap_evt_w[g] = pif.wrap_evt;
      port_counter #(.AW(AW)) u_cnt (
         .pclk      (pclk),
         .dev_rst_n (dev_rst_n),
         .soft_clr  (st_ff.soft_clr),
         .pi        (pif.dev)
      );
   end

   // mailbox, read path, interrupts and apb
   always_comb begin
      logic [NPORT-1:0][AW-1:0] eff;
      logic [NPORT-1:0][DW-1:0] src;
      logic [NPORT-1:0]         acc;
      logic [IRQ_W-1:0]         evt;
      logic [IRQ_W-1:0]         w1c;
      logic                     setup;
      logic                     wr_done;
      nxt_st          = st_ff;
      eff             = '0;
      src             = '0;
      acc             = '0;
      evt             = '0;
      w1c             = '0;
      setup           = psel & ~penable;
      wr_done         = psel & penable & st_ff.pready & pwrite;
      nxt_st.soft_clr = 1'b0;

      // address and access decode per port
      for (int p = 0; p < NPORT; p++) begin
         eff[p] = address_load_strobe_n[p] ? cnt_w[p] : port_addr[p];
         acc[p] = ~chip_enable_n[p] & ~(&byte_enable_n[p]);
         src[p] = is_mbox(eff[p], 0) ? st_ff.mbox[0] : (is_mbox(eff[p], 1) ? st_ff.mbox[1] : '0);
      end

      // flags forced idle by software clear, before any set
      if (st_ff.soft_clr) begin
         nxt_st.mflag_n = '1;
      end

      // owner read clears its flag first
      for (int p = 0; p < NPORT; p++) begin
         if (acc[p] && read_write_n[p] && is_mbox(eff[p], p)) begin
            nxt_st.mflag_n[p] = 1'b1;
         end
      end

      // peer write sets, winning over a clear
      for (int p = 0; p < NPORT; p++) begin
         for (int q = 0; q < NPORT; q++) begin
            if (acc[p] && !read_write_n[p] && is_mbox(eff[p], q)) begin
               nxt_st.mbox[q] = write_data[p];
               if (q != p) begin
                  nxt_st.mflag_n[q]      = 1'b0;
                  evt[IRQ_MBOX_BASE + q] = 1'b1;
               end
            end
         end
         evt[IRQ_WRAP_BASE + p] = wrap_evt_w[p];
      end

      // read data, one edge flow-through or two pipelined
      for (int p = 0; p < NPORT; p++) begin
         if (acc[p] && read_write_n[p]) begin
            nxt_st.rd_stage[p] = src[p];
         end
         nxt_st.rd_out[p] = flow_through_select[p] ? nxt_st.rd_stage[p] : st_ff.rd_stage[p];
      end

      // apb writes at the completing edge
      if (wr_done) begin
         if (paddr == OFS_CTRL) begin
            nxt_st.soft_clr = pwdata[CTRL_SOFT_RST];
         end else if (paddr == OFS_IRQ_STAT) begin
            w1c = pwdata[IRQ_W-1:0];
         end else if (paddr == OFS_IRQ_MASK) begin
            nxt_st.irq_mask = pwdata[IRQ_W-1:0];
         end
      end

      // sticky interrupt status, events win over a clear
      nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | evt;
      nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);

      // apb answer prepared in the setup cycle
      nxt_st.pready  = setup;
      nxt_st.pslverr = setup & ~reg_hit(paddr);
      nxt_st.prdata  = '0;
      if (setup && !pwrite) begin
         if (paddr == OFS_STATUS) begin
            nxt_st.prdata[STAT_MBOX_BASE +: NPORT] = st_ff.mflag_n;
            nxt_st.prdata[STAT_WRAP_BASE +: NPORT] = wrap_n_w;
         end else if (paddr == OFS_IRQ_STAT) begin
            nxt_st.prdata[IRQ_W-1:0] = st_ff.irq_stat;
         end else if (paddr == OFS_IRQ_MASK) begin
            nxt_st.prdata[IRQ_W-1:0] = st_ff.irq_mask;
         end else if (paddr == OFS_CNT_L) begin
            nxt_st.prdata[AW-1:0] = cnt_w[0];
         end else if (paddr == OFS_CNT_R) begin
            nxt_st.prdata[AW-1:0] = cnt_w[1];
         end
      end
   end

   // state register
   // held reset keeps every flop at its idle value
   always_ff @(posedge pclk or negedge dev_rst_n) begin
      if (!dev_rst_n) begin
         st_ff          <= '0;
         st_ff.mflag_n  <= '1;
         st_ff.irq_mask <= IRQ_MASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   assign prdata              = st_ff.prdata;
   assign pready              = st_ff.pready;
   assign pslverr             = st_ff.pslverr;
   assign irq                 = st_ff.irq;
   assign read_data           = st_ff.rd_out;
   assign mailbox_flag_n      = st_ff.mflag_n;
   assign counter_wrap_flag_n = wrap_n_w;
endmodule : dual_port_master_reset_flags
`default_nettype wire

// file: tb/dual_port_master_reset_flags_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module mrf_checker
   import dpr_pkg::*;
#(parameter int AW = ADDR_W) (
   // clock and resets
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      master_reset_n,
   // device outputs
   input wire logic                      irq,
   input wire logic [NPORT-1:0]          mailbox_flag_n,
   input wire logic [NPORT-1:0]          counter_wrap_flag_n,
   // port controls
   input wire logic [NPORT-1:0]          address_load_strobe_n,
   input wire logic [NPORT-1:0]          counter_advance_enable_n,
   input wire logic [NPORT-1:0]          counter_mask_select,
   input wire logic [NPORT-1:0]          chip_enable_n,
   input wire logic [NPORT-1:0]          read_write_n,
   input wire logic [NPORT-1:0][BE_W-1:0] byte_enable_n,
   input wire logic [NPORT-1:0][AW-1:0]   port_addr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !master_reset_n);
   // accesses and increments at the pins
   wire logic [1:0] acc = ~chip_enable_n & ~address_load_strobe_n & {~&byte_enable_n[1], ~&byte_enable_n[0]};
   wire logic [1:0] inc = counter_mask_select & address_load_strobe_n & ~counter_advance_enable_n;
   wire logic [AW-1:0] top = '1;
   AST_RST_FLAGS: assert property (disable iff (!presetn)
      !master_reset_n |-> mailbox_flag_n == 2'h3 && counter_wrap_flag_n == 2'h3) else $error("flags in reset");
   AST_RST_IRQ: assert property (disable iff (!presetn) !master_reset_n |-> !irq)
      else $error("irq in reset");
   AST_REL_HOLD: assert property (disable iff (!presetn) $rose(master_reset_n) |-> &{mailbox_flag_n, counter_wrap_flag_n})
      else $error("flags at release");
   AST_WRAP_SET: assert property ($fell(counter_wrap_flag_n[0]) |-> $past(inc[0]))
      else $error("wrap without increment");
   AST_WRAP_CLR: assert property (!counter_wrap_flag_n[0] && inc[0] |=> counter_wrap_flag_n[0])
      else $error("wrap stuck");
   AST_MBOX_SET: assert property (acc[0] && !read_write_n[0] && port_addr[0] == top |=> !mailbox_flag_n[1])
      else $error("mailbox not set");
   AST_MBOX_CLR: assert property (acc[1] && read_write_n[1] && port_addr[1] == top && !acc[0] |=> mailbox_flag_n[1])
      else $error("mailbox not cleared");
   AST_PEER_RD: assert property (!mailbox_flag_n[1] && acc[0] && read_write_n[0] && !acc[1] |=> !mailbox_flag_n[1])
      else $error("peer read cleared");
endmodule // mrf_checker
`default_nettype wire

// file: tb/port_host.sv
`timescale 1ns/1ns
`default_nettype none
module port_host
   import dpr_pkg::*;
(
   // clock
   input wire logic                      pclk,
   // device reset and port pins
   output logic                          master_reset_n,
   output logic [NPORT-1:0]              address_load_strobe_n,
   output logic [NPORT-1:0]              counter_advance_enable_n,
   output logic [NPORT-1:0]              chip_enable_n,
   output logic [NPORT-1:0]              read_write_n,
   output logic [NPORT-1:0][ADDR_W-1:0]  port_addr,
   output logic [NPORT-1:0][BE_W-1:0]    byte_enable_n,
   output logic [NPORT-1:0][DATA_W-1:0]  write_data
);
   // idle pins, then one reset after power-up
   initial begin
      {address_load_strobe_n, counter_advance_enable_n, chip_enable_n, read_write_n, byte_enable_n} = '1;
      port_addr = '0;
      write_data = '0;
      master_reset_n = 1'b0;
      repeat (8) @(posedge pclk);
      master_reset_n <= 1'b1;
   end
   // one operation held for n edges, released data shows its inverse
   task automatic op(input int p, input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input int n);
      @(posedge pclk);
      {address_load_strobe_n[p], counter_advance_enable_n[p], read_write_n[p], chip_enable_n[p]} <= c;
      port_addr[p] <= a;
      write_data[p] <= d;
      byte_enable_n[p] <= 4'he;
      repeat (n) @(posedge pclk);
      {address_load_strobe_n[p], counter_advance_enable_n[p], read_write_n[p], chip_enable_n[p]} <= 4'hf;
      byte_enable_n[p] <= 4'hf;
      write_data[p] <= ~d;
   endtask
   // master reset pulse held for n edges
   task automatic pulse_reset(input int n);
      master_reset_n <= 1'b0;
      repeat (n) @(posedge pclk);
      master_reset_n <= 1'b1;
   endtask
endmodule // port_host
`default_nettype wire

// file: tb/test_dual_port_master_reset_flags.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %0t: got %0h exp %0h", $time, a, e); end end
module test_dual_port_master_reset_flags
   import dpr_pkg::*;
;
   // bench signals, named as the device pins
   logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err, master_reset_n;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rdat;
   logic [1:0]             address_load_strobe_n, counter_advance_enable_n, chip_enable_n, read_write_n;
   logic [1:0]             mailbox_flag_n, counter_wrap_flag_n, flow_through_select;
   logic [1:0]             counter_reset_n = '1, counter_mask_select = '1;
   logic [1:0][ADDR_W-1:0] port_addr;
   logic [1:0][BE_W-1:0]   byte_enable_n;
   logic [1:0][DATA_W-1:0] write_data, read_data;
   logic [DATA_W-1:0]      dv [2] = '{36'h123456789, 36'h9abcdef01};
   int                     error_cnt = 0, check_count = 0, cyc = 0;
   localparam logic [3:0] LOAD = 4'h3, INC = 4'hb, WR = 4'h4, RD = 4'h6;
   // device and port host
   dual_port_master_reset_flags dual_port_master_reset_flags_inst (.pclk, .presetn, .master_reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .address_load_strobe_n, .counter_advance_enable_n,
      .counter_reset_n, .counter_mask_select, .port_addr, .chip_enable_n, .read_write_n, .byte_enable_n, .write_data,
      .flow_through_select, .read_data, .mailbox_flag_n, .counter_wrap_flag_n);
   port_host port_host_inst (.pclk, .master_reset_n, .address_load_strobe_n, .counter_advance_enable_n,
      .chip_enable_n, .read_write_n, .port_addr, .byte_enable_n, .write_data);
   // clock and run limit
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      last_err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, flow_through_select} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(OFS_STATUS, 32'hf);
      rd(OFS_CNT_R, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      $display("test reset_values done");
      port_host_inst.op(0, LOAD, 18'h3fffc, '0, 1);
      port_host_inst.op(0, INC, '0, '0, 3);
      rd(OFS_CNT_L, 32'h3ffff);
      rd(OFS_STATUS, 32'hb);
      `CHK(counter_wrap_flag_n, 2'h2)
      port_host_inst.op(0, INC, '0, '0, 1);
      rd(OFS_STATUS, 32'hf);
      $display("test counter done");
      apb(1'b1, OFS_IRQ_MASK, 32'h2);
      for (int m = 0; m < 2; m++) begin
         flow_through_select[1] <= m[0];
         port_host_inst.op(0, WR, 18'h3ffff, dv[m], 1);
         rd(OFS_STATUS, 32'hd);
         `CHK(irq, 1'b1)
         `CHK(mailbox_flag_n, 2'h1)
         apb(1'b1, OFS_IRQ_STAT, 32'h2);
         rd(OFS_IRQ_STAT, 32'h4);
         `CHK(irq, 1'b0)
         port_host_inst.op(0, RD, 18'h3ffff, '0, 1);
         rd(OFS_STATUS, 32'hd);
         `CHK(read_data[0], dv[m])
         port_host_inst.op(1, RD, 18'h3ffff, '0, 1);
         #1;
         `CHK(read_data[1], m ? dv[1] : 36'h0)
         @(posedge pclk);
         #1;
         `CHK(read_data[1], dv[m])
         rd(OFS_STATUS, 32'hf);
      end
      apb(1'b1, OFS_IRQ_STAT, 32'hf);
      rd(OFS_IRQ_STAT, 32'h0);
      `CHK(irq, 1'b0)
      $display("test mailbox done");
      counter_mask_select[0] <= 1'b0;
      port_host_inst.op(0, LOAD, 18'h00003, '0, 1);
      counter_mask_select[0] <= 1'b1;
      port_host_inst.op(0, LOAD, 18'h3fffc, '0, 1);
      port_host_inst.op(0, INC, '0, '0, 3);
      port_host_inst.op(1, WR, 18'h3fffe, dv[0], 1);
      apb(1'b1, OFS_IRQ_MASK, 32'hf);
      rd(OFS_STATUS, 32'ha);
      port_host_inst.pulse_reset(3);
      rd(OFS_STATUS, 32'hf);
      rd(OFS_IRQ_MASK, 32'h0);
      `CHK(irq, 1'b0)
      port_host_inst.op(0, INC, '0, '0, 4);
      rd(OFS_CNT_L, 32'h4);
      $display("test master_reset done");
      port_host_inst.op(1, WR, 18'h3fffe, dv[1], 1);
      rd(OFS_STATUS, 32'he);
      apb(1'b1, OFS_CTRL, 32'h1);
      rd(OFS_STATUS, 32'hf);
      rd(OFS_CNT_L, 32'h0);
      $display("test soft_clear done");
      rd(12'h0f0, 32'h0);
      `CHK(last_err, 1'b1)
      $display("test unmapped done");
      close_out();
   end
endmodule // test_dual_port_master_reset_flags
bind dual_port_master_reset_flags mrf_checker #(.AW(AW)) mrf_checker_inst (.pclk, .presetn, .master_reset_n, .irq,
   .mailbox_flag_n, .counter_wrap_flag_n, .address_load_strobe_n, .counter_advance_enable_n, .counter_mask_select,
   .chip_enable_n, .read_write_n, .byte_enable_n, .port_addr);
`default_nettype wire
